// file: hdl/tcp_defs.svh
/*
  Constants of the thermal cluster protection block: register offsets,
  field positions, reset values and filter timing.
  Assumes a 100 MHz pclk and a byte-addressed APB with 32-bit data.
*/
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH

// timing
`define TCP_CLK_MHZ        100
`define TCP_FILTER_US      100
`define TCP_FILTER_CYC     (`TCP_FILTER_US * `TCP_CLK_MHZ)
`define TCP_CNT_W          16

// register byte offsets
`define TCP_SR1_OFF        8'h00
`define TCP_SR2_OFF        8'h04
`define TCP_SR7_OFF        8'h18
`define TCP_SR8_OFF        8'h1C
`define TCP_CR3_OFF        8'h20
`define TCP_IRQ_ST_OFF     8'h24
`define TCP_IRQ_MASK_OFF   8'h28
`define TCP_LIVE_OFF       8'h2C

// field positions
`define TCP_WARN_BIT       8
`define TCP_SD1_BIT        4
`define TCP_SD2_BIT        5
`define TCP_MODE_BIT       0
`define TCP_GLOB_CLR_BIT   31

// reset values
`define TCP_IRQ_MASK_RST   3'h0

`endif

// file: hdl/tcp_pkg.sv
/*
  Types of the thermal cluster protection block.
  Assumes nothing beyond the constants header.
*/
package tcp_pkg;
  // number of thermal clusters
  localparam int unsigned TCP_CLUSTERS = 8;

  typedef logic [TCP_CLUSTERS-1:0] tcp_cluster_t;

  // shutdown scope selected in the mode register
  typedef enum logic {
    TCP_STANDARD = 1'b0,
    TCP_CLUSTER  = 1'b1
  } tcp_mode_t;

  // interrupt event bits
  typedef enum logic [1:0] {
    TCP_EV_WARN = 2'h0,
    TCP_EV_SD1  = 2'h1,
    TCP_EV_SD2  = 2'h2
  } tcp_event_t;
endpackage

// file: hdl/tcp_filter.sv
/*
  Filter timer for one over-threshold indication.
  Assumes the indication is synchronous to pclk.
*/
`timescale 1ns/10ps
`include "tcp_defs.svh"

module tcp_filter #(
  parameter int unsigned CYCLES = `TCP_FILTER_CYC
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // indication and control
  input  wire logic over,
  input  wire logic restart,
  // filtered result
  output logic      hit
);
  localparam logic [`TCP_CNT_W-1:0] LAST = CYCLES[`TCP_CNT_W-1:0];

  logic [`TCP_CNT_W-1:0] cnt;

  // count while held; any gap or restart starts over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (!over || restart) begin
      cnt <= '0; // R16
    end else if (cnt != LAST) begin
      cnt <= cnt + 1'b1;
    end
  end

  // stays high while the indication stays held past the filter time;
  // a restart masks it, else a clear while still hot is undone at once
  assign hit = over && !restart && (cnt == LAST);

  // a dropped or restarted indication cannot hit on the next edge
  restart_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
    (!over || restart) |=> !hit)
    else $error("filter hit right after a gap or restart");
endmodule

// file: hdl/tcp_thermal_protect.sv
/*
  Thermal warning and shutdown control over eight sensor clusters, with
  an APB register file and a level interrupt.
  Assumes sensor indications synchronous to pclk and a zero-wait APB master.
*/
// What this block does
// R1: any cluster above warning threshold sets warning flag after filter time.
// R2: above shutdown threshold, after filter, set shutdown flag, switch off outputs.
// R3: on shutdown, gate drivers go resistive low to discharge external gates; here only on a full shutdown (standard mode, or cluster eight in cluster mode).
// R4: flags stay latched until host clears them; bit 31 clears all but the second-level flag at any register.
// R5: first shutdown flag at status eight bit 4, warning at status seven bit 8.
// R6: outputs come back once the latched flags are cleared.
// R7: after clear, warning after one period, shutdown after another.
// R8: eight clusters, each with its own sensor input.
// R9: each cluster has latched warning and shutdown flags in two registers.
// R10: mode bit in control register three picks standard or cluster mode.
// R11: standard mode ORs sensors; shutdown kills drivers, pump, aux, transmitters.
// R12: main regulator stays on until second shutdown level.
// R13: cluster mode turns off only the cluster that reached shutdown.
// R14: cluster seven shutdown turns off both high sides and aux regulator.
// R15: cluster eight shutdown turns off everything like standard mode.
// R16: a filter restarts whenever its indication drops before expiry.
`timescale 1ns/10ps
`include "tcp_defs.svh"

module tcp_thermal_protect
  import tcp_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = `TCP_FILTER_CYC
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // cluster sensor indications
  input  wire tcp_cluster_t warn_over,
  input  wire tcp_cluster_t sd1_over,
  input  wire logic         sd2_over,
  // power stage controls
  output tcp_cluster_t      cluster_off,
  output logic              drivers_all_off,
  output logic              highside_zero_off,
  output logic              highside_fifteen_off,
  output logic              charge_pump_off,
  output logic              aux_regulator_off,
  output logic              main_regulator_off,
  output logic              tx_receive_only,
  output logic              gate_resistive_low,
  // interrupt
  output logic              irq
);
  localparam int unsigned CL_SEVEN = 6;
  localparam int unsigned CL_EIGHT = 7;

  tcp_cluster_t cl_warn;
  tcp_cluster_t cl_sd;
  tcp_cluster_t warn_hit;
  tcp_cluster_t sd_hit;
  tcp_cluster_t clr_cl_warn;
  tcp_cluster_t clr_cl_sd;
  tcp_mode_t    cluster_mode_select;
  logic         warn_flag;
  logic         first_shutdown_level;
  logic         second_shutdown_level;
  logic         sd2_hit;
  logic [2:0]   irq_st;
  logic [2:0]   irq_mask;
  logic [2:0]   irq_ev;
  logic         wr;
  logic         setup;
  logic         addr_ok;
  logic         glob_clr;
  logic         clr_tw;
  logic         clr_sd1;
  logic         clr_sd2;
  logic [2:0]   clr_irq;
  logic         next_all_off;
  logic         cm;
  logic         any_warn_hit;
  logic         irq_pend;

  // bus decode; writes land at the access edge
  assign wr      = psel && penable && pwrite;
  assign setup   = psel && !penable;
  assign pready  = 1'b1;
  assign cm      = (cluster_mode_select == TCP_CLUSTER);
  assign addr_ok = (paddr == `TCP_SR1_OFF) || (paddr == `TCP_SR2_OFF) ||
                   (paddr == `TCP_SR7_OFF) || (paddr == `TCP_SR8_OFF) ||
                   (paddr == `TCP_CR3_OFF) || (paddr == `TCP_IRQ_ST_OFF) ||
                   (paddr == `TCP_IRQ_MASK_OFF) || (paddr == `TCP_LIVE_OFF);

  // global clear bit works at any mapped address
  assign glob_clr    = wr && addr_ok && pwdata[`TCP_GLOB_CLR_BIT]; // R4
  assign clr_cl_warn = ({TCP_CLUSTERS{wr && paddr == `TCP_SR1_OFF}} & pwdata[7:0]) |
                       {TCP_CLUSTERS{glob_clr}};
  assign clr_cl_sd   = ({TCP_CLUSTERS{wr && paddr == `TCP_SR2_OFF}} & pwdata[7:0]) |
                       {TCP_CLUSTERS{glob_clr}};
  assign clr_tw  = glob_clr || (wr && paddr == `TCP_SR7_OFF && pwdata[`TCP_WARN_BIT]);
  assign clr_sd1 = glob_clr || (wr && paddr == `TCP_SR8_OFF && pwdata[`TCP_SD1_BIT]);
  assign clr_sd2 = wr && paddr == `TCP_SR8_OFF && pwdata[`TCP_SD2_BIT];
  assign clr_irq = {3{wr && paddr == `TCP_IRQ_ST_OFF}} & pwdata[2:0];

  // one warning and one shutdown filter per cluster
  for (genvar i = 0; i < TCP_CLUSTERS; i++) begin : g_cl // R8
    tcp_filter #(.CYCLES(FILTER_CYCLES)) u_warn (
      .pclk    (pclk),
      .presetn (presetn),
      .over    (warn_over[i]),
      .restart (clr_cl_warn[i]),
      .hit     (warn_hit[i])
    );
    // shutdown filter only runs once warning is latched: two periods total
    tcp_filter #(.CYCLES(FILTER_CYCLES)) u_sd (
      .pclk    (pclk),
      .presetn (presetn),
      .over    (sd1_over[i] && cl_warn[i]), // R7
      .restart (clr_cl_sd[i]),
      .hit     (sd_hit[i])
    );

    // each cluster shutdown flag needs its warning latched two edges before
    two_period_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
      $rose(cl_sd[i]) |-> $past(cl_warn[i], 2))
      else $error("cluster shutdown without prior warning period");
  end

  // second shutdown level filter
  tcp_filter #(.CYCLES(FILTER_CYCLES)) u_sd2 (
    .pclk    (pclk),
    .presetn (presetn),
    .over    (sd2_over),
    .restart (clr_sd2),
    .hit     (sd2_hit)
  );

  // per-cluster sticky flags; a clear restarts that cluster's filter, so the clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_warn <= '0;
      cl_sd   <= '0;
    end else begin
      cl_warn <= (cl_warn & ~clr_cl_warn) | warn_hit; // R9
      cl_sd   <= (cl_sd & ~clr_cl_sd) | sd_hit; // R9
    end
  end

  // global sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_flag             <= 1'b0;
      first_shutdown_level  <= 1'b0;
      second_shutdown_level <= 1'b0;
    end else begin
      warn_flag             <= (warn_flag & ~clr_tw) | (|warn_hit); // R1
      first_shutdown_level  <= (first_shutdown_level & ~clr_sd1) | (|sd_hit); // R2
      second_shutdown_level <= (second_shutdown_level & ~clr_sd2) | sd2_hit;
    end
  end

  // mode and interrupt mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cluster_mode_select <= TCP_STANDARD;
      irq_mask            <= `TCP_IRQ_MASK_RST;
    end else begin
      if (wr && paddr == `TCP_CR3_OFF) begin
        cluster_mode_select <= tcp_mode_t'(pwdata[`TCP_MODE_BIT]); // R10
      end
      if (wr && paddr == `TCP_IRQ_MASK_OFF) begin
        irq_mask <= pwdata[2:0];
      end
    end
  end

  // interrupt events: new flags only, not flags already standing
  assign irq_ev[TCP_EV_WARN] = |(warn_hit & ~cl_warn);
  assign irq_ev[TCP_EV_SD1]  = |(sd_hit & ~cl_sd);
  assign irq_ev[TCP_EV_SD2]  = sd2_hit && !second_shutdown_level;

  // reductions kept as nets; irq_pend feeds the irq flop and an assertion, any_warn_hit an assertion
  assign any_warn_hit = |warn_hit;
  assign irq_pend     = |(irq_st & irq_mask);

  // interrupt status and output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st <= 3'h0;
      irq    <= 1'b0;
    end else begin
      irq_st <= (irq_st & ~clr_irq) | irq_ev;
      irq    <= irq_pend;
    end
  end

  // standard mode ORs all clusters; cluster eight takes everything down
  assign next_all_off = cm ? cl_sd[CL_EIGHT] : first_shutdown_level; // R11 R15

  // power stage controls follow the latched flags, so clearing restores them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cluster_off          <= '0;
      drivers_all_off      <= 1'b0;
      highside_zero_off    <= 1'b0;
      highside_fifteen_off <= 1'b0;
      charge_pump_off      <= 1'b0;
      aux_regulator_off    <= 1'b0;
      main_regulator_off   <= 1'b0;
      tx_receive_only      <= 1'b0;
      gate_resistive_low   <= 1'b0;
    end else begin
      drivers_all_off      <= next_all_off; // R2 R6
      cluster_off          <= {TCP_CLUSTERS{next_all_off}} |
                              ({TCP_CLUSTERS{cm}} & cl_sd); // R13
      highside_zero_off    <= next_all_off || (cm && cl_sd[CL_SEVEN]); // R14
      highside_fifteen_off <= next_all_off || (cm && cl_sd[CL_SEVEN]); // R14
      aux_regulator_off    <= next_all_off || (cm && cl_sd[CL_SEVEN]); // R14
      charge_pump_off      <= next_all_off; // R11
      tx_receive_only      <= next_all_off; // R11
      main_regulator_off   <= second_shutdown_level; // R12
      gate_resistive_low   <= next_all_off; // R3
    end
  end

  // read data and error sampled in setup, valid through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !addr_ok;
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `TCP_SR1_OFF:      prdata[7:0] <= cl_warn;
          `TCP_SR2_OFF:      prdata[7:0] <= cl_sd;
          `TCP_SR7_OFF:      prdata[`TCP_WARN_BIT] <= warn_flag; // R5
          `TCP_SR8_OFF: begin
            prdata[`TCP_SD1_BIT] <= first_shutdown_level; // R5
            prdata[`TCP_SD2_BIT] <= second_shutdown_level;
          end
          `TCP_CR3_OFF:      prdata[`TCP_MODE_BIT] <= cluster_mode_select;
          `TCP_IRQ_ST_OFF:   prdata[2:0] <= irq_st;
          `TCP_IRQ_MASK_OFF: prdata[2:0] <= irq_mask;
          `TCP_LIVE_OFF:     prdata[16:0] <= {sd2_over, sd1_over, warn_over};
          default:           prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // warning flag rises only from a filtered hit
  warn_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    $rose(warn_flag) |-> $past(any_warn_hit))
    else $error("warning flag rose without a filter hit");

  // standard-mode shutdown cuts every driver next cycle
  sd_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (!cm && first_shutdown_level) |=> drivers_all_off)
    else $error("drivers not off after shutdown flag");

  // gates discharge whenever drivers are forced off
  gate_rl_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    drivers_all_off |-> gate_resistive_low)
    else $error("gate drivers not resistive low on shutdown");

  // shutdown flag only falls by a host clear
  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    $fell(first_shutdown_level) |-> $past(clr_sd1))
    else $error("shutdown flag dropped without clear");

  // status eight read shows the first-level flag at bit 4
  sr8_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (setup && !pwrite && paddr == `TCP_SR8_OFF) |=>
      prdata[`TCP_SD1_BIT] == $past(first_shutdown_level))
    else $error("status eight bit 4 wrong on read");

  // outputs return once flags are gone
  reactivate_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (!cm && !first_shutdown_level) |=> !drivers_all_off)
    else $error("outputs not restored after clear");

  // cluster mode isolates the hot clusters unless cluster eight is among them
  cluster_only_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    (cm && !cl_sd[CL_EIGHT]) |=> (cluster_off == $past(cl_sd) && !drivers_all_off))
    else $error("cluster mode shut more than the hot cluster");

  // cluster seven kills both high sides and aux, not main
  cl_seven_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    (cm && cl_sd[CL_SEVEN] && !second_shutdown_level) |=>
      (highside_zero_off && highside_fifteen_off && aux_regulator_off &&
       !main_regulator_off))
    else $error("cluster seven shutdown outputs wrong");

  // main regulator follows only the second level
  main_reg_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    !second_shutdown_level |=> !main_regulator_off)
    else $error("main regulator off below second level");

  // cluster eight in cluster mode behaves like a full shutdown
  cl_eight_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    (cm && cl_sd[CL_EIGHT]) |=> (drivers_all_off && charge_pump_off && tx_receive_only))
    else $error("cluster eight shutdown incomplete");

  // standard mode shutdown also takes pump, aux, transmitters, all clusters
  std_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (!cm && first_shutdown_level) |=>
      (charge_pump_off && aux_regulator_off && tx_receive_only && cluster_off == 8'hFF))
    else $error("standard shutdown left a stage on");

  // standard mode shutdown also takes both high sides and the gate drivers
  hs_std_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (!cm && first_shutdown_level) |=>
      (highside_zero_off && highside_fifteen_off && gate_resistive_low))
    else $error("standard shutdown left a high side on");

  // writing a one to the mode bit selects cluster mode
  mode_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (wr && paddr == `TCP_CR3_OFF && pwdata[`TCP_MODE_BIT]) |=> cm)
    else $error("cluster mode not taken from control register three");

  // every cluster hit latches that cluster's warning flag
  warn_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (warn_hit != 8'h00) |=>
      ((cl_warn & $past(warn_hit)) == $past(warn_hit)))
    else $error("cluster warning flag not latched on hit");

  // second level takes the main regulator down
  sd2_main_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
    second_shutdown_level |=> main_regulator_off)
    else $error("main regulator still on at second level");

  // cluster outputs come back once no cluster flag stands
  cl_restore_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (cm && cl_sd == 8'h00) |=> (cluster_off == 8'h00))
    else $error("cluster outputs not restored after clear");

  // the global clear drops every warning and first-level flag
  clr_all_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
    glob_clr |=>
      (!warn_flag && !first_shutdown_level && cl_warn == 8'h00 && cl_sd == 8'h00))
    else $error("global clear left a flag standing");

  // an unmasked pending event raises the interrupt one edge later
  irq_pend_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_pend |=> irq)
    else $error("interrupt not raised for an unmasked event");
endmodule

// file: testbench/tcp_host_model.sv
/*
  Host model: an APB master that reads the protection flags and clears them.
  Assumes pclk from the bench and one transfer at a time.
*/
`timescale 1ns/10ps

module tcp_host_model (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic        hung;
  logic [31:0] rdata;
  logic        rerr;

  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    hung    = 1'b0;
  end

  // one transfer; the request stands until pready is sampled high, for at most 50 edges
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) hung = 1'b1; // slave never answered
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // clear latched flags; a set bit 31 clears all but the second-level flag at any register
  task automatic clear_flags(input logic [7:0] a, input logic [31:0] m);
    xfer(1'b1, a, m);
  endtask
endmodule

// file: testbench/tb_top.sv
/*
  Testbench of the thermal protection block: random cluster, filter,
  latching, standard and cluster mode, second level, interrupt.
  Assumes a short filter parameter so each run stays brief.
*/
`timescale 1ns/10ps
`include "tcp_defs.svh"

module tb_top;
  import tcp_pkg::*;
  localparam int unsigned FC = 8;
  logic         pclk;
  logic         presetn;
  logic         psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  tcp_cluster_t warn_over, sd1_over, cluster_off;
  logic         sd2_over, drivers_all_off, highside_zero_off, highside_fifteen_off;
  logic         charge_pump_off, aux_regulator_off, main_regulator_off;
  logic         tx_receive_only, gate_resistive_low;
  int           num_errors = 0;
  int           total_checks = 0;
  int           cyc;
  int           c;

  always #5 pclk = ~pclk;

  tcp_thermal_protect #(.FILTER_CYCLES(FC)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .warn_over, .sd1_over,
    .sd2_over, .cluster_off, .drivers_all_off, .highside_zero_off, .highside_fifteen_off,
    .charge_pump_off, .aux_regulator_off, .main_regulator_off, .tx_receive_only,
    .gate_resistive_low, .irq);

  tcp_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);

  task automatic final_report;
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus access; a hung slave ends the run
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(wr, a, d);
    if (u_host.hung) begin
      chk(32'h0, 32'h1); // slave never answered
      final_report();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(u_host.rdata, e);
  endtask

  // wait for a stage-off output, bounded; cyc counts edges
  task automatic wait_off(input int w);
    cyc = 0;
    do begin
      @(posedge pclk);
      #1;
      cyc++;
    end while ((w == 0 ? drivers_all_off : w == 1 ? |cluster_off : main_regulator_off)
               !== 1'b1 && cyc < 300);
    if (cyc >= 300) begin
      chk(32'(cyc), 32'h0); // stage never went off
      final_report();
    end
  endtask

  // expected {drivers, pump, tx, aux, main} in cluster mode
  function automatic logic [4:0] exp_cl(input int k);
    return (k == 7) ? 5'h1E : (k == 6) ? 5'h02 : 5'h00;
  endfunction

  // expected per-cluster off mask in cluster mode; cluster eight takes all
  function automatic logic [7:0] exp_off(input int k);
    return (k == 7) ? 8'hFF : 8'(1 << k);
  endfunction

  // let n edges pass, then sample once the outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic heat(input logic on);
    @(posedge pclk);
    warn_over[c] <= on;
    sd1_over[c]  <= on;
  endtask

  initial begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    warn_over = '0;
    sd1_over  = '0;
    sd2_over  = 1'b0;
    c         = $urandom(32'h0230);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    rd(`TCP_CR3_OFF, 32'h0);
    rd(`TCP_SR7_OFF, 32'h0);
    acc(1'b1, 8'h30, 32'hFFFF_FFFF);
    chk(32'(u_host.rerr), 32'h1);
    rd(8'h30, 32'h0);
    // short pulses must never latch a flag
    c = $urandom % 8;
    repeat (3) begin
      @(posedge pclk);
      warn_over[c] <= 1'b1;
      repeat (FC / 2) @(posedge pclk);
      warn_over[c] <= 1'b0;
    end
    rd(`TCP_SR1_OFF, 32'h0);
    // standard mode shutdown of a random cluster
    heat(1'b1);
    wait_off(0);
    chk(32'(cyc >= 2 * FC), 32'h1);
    chk(32'({drivers_all_off, charge_pump_off, aux_regulator_off, tx_receive_only,
             gate_resistive_low, main_regulator_off}), 32'h3E);
    chk(32'(cluster_off), 32'hFF);
    rd(`TCP_SR1_OFF, 32'h1 << c);
    rd(`TCP_SR2_OFF, 32'h1 << c);
    rd(`TCP_SR7_OFF, 32'h100);
    rd(`TCP_SR8_OFF, 32'h10);
    // interrupt: unmask, check, clear
    acc(1'b1, `TCP_IRQ_MASK_OFF, 32'h7);
    settle(2);
    chk(32'(irq), 32'h1);
    rd(`TCP_IRQ_ST_OFF, 32'h3);
    acc(1'b1, `TCP_IRQ_ST_OFF, 32'h7);
    settle(2);
    chk(32'(irq), 32'h0);
    // clear while still hot: outputs return, then trip again
    u_host.clear_flags(`TCP_SR1_OFF, 32'h8000_0000);
    settle(2);
    chk(32'(drivers_all_off), 32'h0);
    wait_off(0);
    chk(32'(cyc >= 2 * FC - 2), 32'h1);
    heat(1'b0);
    repeat (5) @(posedge pclk);
    rd(`TCP_SR8_OFF, 32'h10);
    u_host.clear_flags(`TCP_CR3_OFF, 32'h8000_0000);
    settle(2);
    chk(32'(drivers_all_off), 32'h0);
    rd(`TCP_SR7_OFF, 32'h0);
    // second level alone takes the main regulator
    @(posedge pclk);
    sd2_over <= 1'b1;
    wait_off(2);
    @(posedge pclk);
    sd2_over <= 1'b0;
    u_host.clear_flags(`TCP_SR8_OFF, 32'h20);
    settle(2);
    chk(32'(main_regulator_off), 32'h0);
    // cluster mode: seven, eight, then a random plain cluster
    acc(1'b1, `TCP_CR3_OFF, 32'h1);
    rd(`TCP_CR3_OFF, 32'h1);
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 6 : (k == 1) ? 7 : $urandom % 6;
      heat(1'b1);
      wait_off(1);
      settle(2);
      chk(32'(cluster_off), 32'(exp_off(c)));
      chk(32'({drivers_all_off, charge_pump_off, tx_receive_only, aux_regulator_off,
               main_regulator_off}), 32'(exp_cl(c)));
      chk(32'({highside_zero_off, highside_fifteen_off}), (c >= 6) ? 32'h3 : 32'h0);
      heat(1'b0);
      u_host.clear_flags(`TCP_SR2_OFF, 32'h8000_0000);
      settle(2);
      chk(32'(cluster_off), 32'h0);
    end
    // mid-run reset brings back standard mode
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TCP_CR3_OFF, 32'h0);
    final_report();
  end
endmodule
